// File: src/cem_regs.svh
// register offsets, field layout, reset values and widths of the converter event mask block
`ifndef CEM_REGS_SVH
`define CEM_REGS_SVH

`define CEM_ADDR_W 8
`define CEM_DATA_W 8
`define CEM_NUM_CONV 4
`define CEM_NUM_EV 8

`define CEM_OFS_MASK01 8'h1f
`define CEM_OFS_MASK23 8'h20

// bit positions, identical in both mask registers
`define CEM_BIT_HI_GOOD 6
`define CEM_BIT_HI_OC 4
`define CEM_BIT_LO_GOOD 2
`define CEM_BIT_LO_OC 0

// bits 7 and 3 are reserved but store; bits 5 and 1 read as zero
`define CEM_MASK_WRITABLE 8'hdd
`define CEM_MASK_RESET 8'h44

`endif

// File: src/cem_pkg.sv
// types of the converter event mask block
`include "cem_regs.svh"

package cem_pkg;

   typedef struct packed {
      logic [`CEM_NUM_CONV-1:0] goodMeta;
      logic [`CEM_NUM_CONV-1:0] limMeta;
      logic [`CEM_NUM_CONV-1:0] goodRaw;
      logic [`CEM_NUM_CONV-1:0] limRaw;
      logic [`CEM_NUM_CONV-1:0] goodPrev;
      logic [`CEM_NUM_CONV-1:0] limPrev;
      logic [`CEM_DATA_W-1:0] mask01;
      logic [`CEM_DATA_W-1:0] mask23;
      logic [`CEM_NUM_EV-1:0] flags;
      logic [`CEM_DATA_W-1:0] rdData;
      logic irqLineN;
   } cem_state_s;

endpackage : cem_pkg

// File: src/cem_event_mask.sv
// converter event mask registers, event detection, interrupt flags and host interrupt line
//
// Function
// - mask01 bit 6 blocks converter 1 good
// - mask01 bit 4 blocks converter 1 overcurrent
// - mask01 bit 2 blocks converter 0 good
// - mask01 bit 0 blocks converter 0 overcurrent
// - mask23 bit 6 blocks converter 3 good
// - mask23 bit 4 blocks converter 3 overcurrent
// - mask23 bit 2 blocks converter 2 good
// - mask23 bit 0 blocks converter 2 overcurrent
// - one blocks, zero permits, every mask bit
// - raw status unaffected by any mask
// - raw good reads one below threshold
`timescale 1ns/1ps
`include "cem_regs.svh"

module cem_event_mask (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [`CEM_NUM_CONV-1:0] convBelowGood,
   input wire logic [`CEM_NUM_CONV-1:0] convCurLimit,
   input wire logic [`CEM_ADDR_W-1:0] regAddr,
   input wire logic regWrEn,
   input wire logic [`CEM_DATA_W-1:0] regWrData,
   input wire logic regRdEn,
   input wire logic [`CEM_NUM_EV-1:0] flagClear,
   output logic [`CEM_DATA_W-1:0] regRdData,
   output logic [`CEM_NUM_CONV-1:0] convGoodRaw,
   output logic [`CEM_NUM_CONV-1:0] convOvercurrentRaw,
   output logic [`CEM_NUM_EV-1:0] irqFlags,
   output logic hostIrqLineN
);

   cem_pkg::cem_state_s st_q;
   cem_pkg::cem_state_s st_d;
   logic [`CEM_NUM_EV-1:0] events;
   logic [`CEM_NUM_EV-1:0] blocked;

   // gather the four block bits of one register in flag order: lo oc, lo good, hi oc, hi good
   function automatic logic [3:0] block_bits(input logic [`CEM_DATA_W-1:0] m);
      block_bits = {m[`CEM_BIT_HI_GOOD], m[`CEM_BIT_HI_OC], m[`CEM_BIT_LO_GOOD], m[`CEM_BIT_LO_OC]};
   endfunction : block_bits

   // events: any change of the good level, rising edge of current limit
   always_comb begin
      for (int i = 0; i < `CEM_NUM_CONV; i++) begin
         events[2*i] = st_q.limRaw[i] & ~st_q.limPrev[i];
         events[2*i+1] = st_q.goodRaw[i] ^ st_q.goodPrev[i];
      end
      blocked = {block_bits(st_q.mask23), block_bits(st_q.mask01)};
   end

   // next state of the whole block
   always_comb begin
      st_d = st_q;
      // pins are asynchronous, two flops before anything looks at them
      st_d.goodMeta = convBelowGood;
      st_d.limMeta = convCurLimit;
      st_d.goodRaw = st_q.goodMeta;
      st_d.limRaw = st_q.limMeta;
      st_d.goodPrev = st_q.goodRaw;
      st_d.limPrev = st_q.limRaw;
      // reserved bits 5 and 1 never store, so they read back as zero
      if (regWrEn && regAddr == `CEM_OFS_MASK01) begin
         st_d.mask01 = regWrData & `CEM_MASK_WRITABLE;
      end
      if (regWrEn && regAddr == `CEM_OFS_MASK23) begin
         st_d.mask23 = regWrData & `CEM_MASK_WRITABLE;
      end
      // set wins over a clear in the same cycle so no event is lost
      st_d.flags = (st_q.flags & ~flagClear) | (events & ~blocked);
      st_d.irqLineN = ~(|st_d.flags);
      if (regRdEn) begin
         unique case (regAddr)
            `CEM_OFS_MASK01: st_d.rdData = st_q.mask01;
            `CEM_OFS_MASK23: st_d.rdData = st_q.mask23;
            default: st_d.rdData = '0;
         endcase
      end
   end

   // single state register; masks come up with both good interrupts blocked
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '0;
         st_q.mask01 <= `CEM_MASK_RESET;
         st_q.mask23 <= `CEM_MASK_RESET;
         st_q.irqLineN <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign regRdData = st_q.rdData;
   assign convGoodRaw = st_q.goodRaw;
   assign convOvercurrentRaw = st_q.limRaw;
   assign irqFlags = st_q.flags;
   assign hostIrqLineN = st_q.irqLineN;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   property p_c1_good_blocked;
      (st_q.mask01[6] && events[3] && !st_q.flags[3] && !flagClear[3]) |=> !st_q.flags[3];
   endproperty
   a_c1_good_blocked: assert property (p_c1_good_blocked) else $error("conv1 good flag set while blocked");

   property p_c1_oc_open;
      (!st_q.mask01[4] && events[2]) |=> st_q.flags[2] && !hostIrqLineN;
   endproperty
   a_c1_oc_open: assert property (p_c1_oc_open) else $error("conv1 overcurrent not flagged");

   property p_c0_good_blocked;
      (st_q.mask01[2] && events[1] && !st_q.flags[1] && !flagClear[1]) |=> !st_q.flags[1];
   endproperty
   a_c0_good_blocked: assert property (p_c0_good_blocked) else $error("conv0 good flag set while blocked");

   property p_c0_oc_open;
      (!st_q.mask01[0] && events[0]) |=> st_q.flags[0];
   endproperty
   a_c0_oc_open: assert property (p_c0_oc_open) else $error("conv0 overcurrent not flagged");

   property p_c3_good_blocked;
      (st_q.mask23[6] && events[7] && !st_q.flags[7] && !flagClear[7]) |=> !st_q.flags[7];
   endproperty
   a_c3_good_blocked: assert property (p_c3_good_blocked) else $error("conv3 good flag set while blocked");

   property p_c3_oc_open;
      (!st_q.mask23[4] && events[6]) |=> st_q.flags[6];
   endproperty
   a_c3_oc_open: assert property (p_c3_oc_open) else $error("conv3 overcurrent not flagged");

   // stored value of a mask after a write; shared by both write checks
   function automatic logic mask_ok(input logic [7:0] m, input logic [7:0] w);
      mask_ok = (m == (w & `CEM_MASK_WRITABLE));
   endfunction : mask_ok

   property p_mask23_write;
      (regWrEn && regAddr == `CEM_OFS_MASK23) |=> mask_ok(st_q.mask23, $past(regWrData));
   endproperty
   a_mask23_write: assert property (p_mask23_write) else $error("mask23 write not stored");

   property p_mask01_write;
      (regWrEn && regAddr == `CEM_OFS_MASK01) |=> mask_ok(st_q.mask01, $past(regWrData));
   endproperty
   a_mask01_write: assert property (p_mask01_write) else $error("mask01 write not stored");

   property p_raw_tracks;
      (convGoodRaw == $past(convBelowGood, 2)) && (convOvercurrentRaw == $past(convCurLimit, 2));
   endproperty
   a_raw_tracks: assert property (p_raw_tracks) else $error("raw status does not follow pins");

   property p_irq_line;
      (|irqFlags) == !hostIrqLineN;
   endproperty
   a_irq_line: assert property (p_irq_line) else $error("interrupt line disagrees with flags");

   property p_blocked_quiet;
      ((events & blocked) != '0) ##1 (irqFlags == '0) |-> hostIrqLineN;
   endproperty
   a_blocked_quiet: assert property (p_blocked_quiet) else $error("blocked event drove interrupt");

   // remaining mask bits, each in both settings; an already set flag would hide a blocked event,
   // so the blocked checks only look where the flag starts clear
   property p_c0_oc_blocked;
      (st_q.mask01[`CEM_BIT_LO_OC] && events[0] && !st_q.flags[0] && !flagClear[0]) |=> !st_q.flags[0];
   endproperty
   a_c0_oc_blocked: assert property (p_c0_oc_blocked) else $error("conv0 oc flagged while blocked");

   property p_c0_good_open;
      (!st_q.mask01[`CEM_BIT_LO_GOOD] && events[1]) |=> st_q.flags[1];
   endproperty
   a_c0_good_open: assert property (p_c0_good_open) else $error("conv0 good not flagged");

   property p_c1_oc_blocked;
      (st_q.mask01[`CEM_BIT_HI_OC] && events[2] && !st_q.flags[2] && !flagClear[2]) |=> !st_q.flags[2];
   endproperty
   a_c1_oc_blocked: assert property (p_c1_oc_blocked) else $error("conv1 oc flagged while blocked");

   property p_c1_good_open;
      (!st_q.mask01[`CEM_BIT_HI_GOOD] && events[3]) |=> st_q.flags[3];
   endproperty
   a_c1_good_open: assert property (p_c1_good_open) else $error("conv1 good not flagged");

   property p_c2_oc_blocked;
      (st_q.mask23[`CEM_BIT_LO_OC] && events[4] && !st_q.flags[4] && !flagClear[4]) |=> !st_q.flags[4];
   endproperty
   a_c2_oc_blocked: assert property (p_c2_oc_blocked) else $error("conv2 oc flagged while blocked");

   property p_c2_oc_open;
      (!st_q.mask23[`CEM_BIT_LO_OC] && events[4]) |=> st_q.flags[4];
   endproperty
   a_c2_oc_open: assert property (p_c2_oc_open) else $error("conv2 overcurrent not flagged");

   property p_c2_good_blocked;
      (st_q.mask23[`CEM_BIT_LO_GOOD] && events[5] && !st_q.flags[5] && !flagClear[5]) |=> !st_q.flags[5];
   endproperty
   a_c2_good_blocked: assert property (p_c2_good_blocked) else $error("conv2 good flagged while blocked");

   property p_c2_good_open;
      (!st_q.mask23[`CEM_BIT_LO_GOOD] && events[5]) |=> st_q.flags[5];
   endproperty
   a_c2_good_open: assert property (p_c2_good_open) else $error("conv2 good not flagged");

   property p_c3_oc_blocked;
      (st_q.mask23[`CEM_BIT_HI_OC] && events[6] && !st_q.flags[6] && !flagClear[6]) |=> !st_q.flags[6];
   endproperty
   a_c3_oc_blocked: assert property (p_c3_oc_blocked) else $error("conv3 oc flagged while blocked");

   property p_c3_good_open;
      (!st_q.mask23[`CEM_BIT_HI_GOOD] && events[7]) |=> st_q.flags[7];
   endproperty
   a_c3_good_open: assert property (p_c3_good_open) else $error("conv3 good not flagged");

   // register side: masks move only on their own write, reserved bits 5 and 1 never store,
   // and a read returns the value from before any write in the same cycle
   property p_mask01_hold;
      !(regWrEn && regAddr == `CEM_OFS_MASK01) |=> $stable(st_q.mask01);
   endproperty
   a_mask01_hold: assert property (p_mask01_hold) else $error("mask01 changed without a write");

   property p_mask23_hold;
      !(regWrEn && regAddr == `CEM_OFS_MASK23) |=> $stable(st_q.mask23);
   endproperty
   a_mask23_hold: assert property (p_mask23_hold) else $error("mask23 changed without a write");

   property p_reserved_zero;
      ((st_q.mask01 | st_q.mask23) & ~`CEM_MASK_WRITABLE) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("read-zero mask bit stored");

   property p_read01;
      (regRdEn && regAddr == `CEM_OFS_MASK01) |=> regRdData == $past(st_q.mask01);
   endproperty
   a_read01: assert property (p_read01) else $error("mask01 read returned wrong value");

   property p_read23;
      (regRdEn && regAddr == `CEM_OFS_MASK23) |=> regRdData == $past(st_q.mask23);
   endproperty
   a_read23: assert property (p_read23) else $error("mask23 read returned wrong value");

   property p_unmapped_read;
      (regRdEn && regAddr != `CEM_OFS_MASK01 && regAddr != `CEM_OFS_MASK23) |=> regRdData == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_rd_hold;
      !regRdEn |=> $stable(regRdData);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

   // reset values, checked at the first edge after release while the outputs still show them
   property p_rst_mask01;
      $fell(sys_rst) |-> st_q.mask01 == `CEM_MASK_RESET;
   endproperty
   a_rst_mask01: assert property (p_rst_mask01) else $error("mask01 reset value wrong");

   property p_rst_mask23;
      $fell(sys_rst) |-> st_q.mask23 == `CEM_MASK_RESET;
   endproperty
   a_rst_mask23: assert property (p_rst_mask23) else $error("mask23 reset value wrong");

   // flag vector as a whole: sticky, set wins over clear, no flag without an open event
   property p_flag_sticky;
      (irqFlags & $past(irqFlags & ~flagClear)) == $past(irqFlags & ~flagClear);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without a clear");

   property p_unblocked_sets;
      (irqFlags & $past(events & ~blocked)) == $past(events & ~blocked);
   endproperty
   a_unblocked_sets: assert property (p_unblocked_sets) else $error("open event lost");

   property p_no_spurious;
      ((irqFlags & ~$past(irqFlags)) & ~$past(events & ~blocked)) == 8'h00;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("flag set without an open event");

   property p_clear_drops;
      (irqFlags & $past(flagClear & ~(events & ~blocked))) == 8'h00;
   endproperty
   a_clear_drops: assert property (p_clear_drops) else $error("cleared flag still set");

   // interrupt line follows the flags one edge later than the events
   property p_quiet_when_blocked;
      ((irqFlags & ~flagClear) == 8'h00 && (events & ~blocked) == 8'h00) |=> hostIrqLineN;
   endproperty
   a_quiet_when_blocked: assert property (p_quiet_when_blocked) else $error("interrupt without open flag");

   property p_irq_follows_set;
      ((events & ~blocked) != 8'h00) |=> !hostIrqLineN;
   endproperty
   a_irq_follows_set: assert property (p_irq_follows_set) else $error("open event gave no interrupt");

   c_unmasked_irq: cover property (events[0] && !blocked[0] ##1 !hostIrqLineN);
   c_masked_event: cover property (events[3] && blocked[3]);
   c_set_and_clear: cover property (events[2] && !blocked[2] && flagClear[2] ##1 irqFlags[2]);
   c_read_mask: cover property (regRdEn && regAddr == `CEM_OFS_MASK23 ##1 regRdData != '0);
   c_flag_cleared: cover property (irqFlags[1] && flagClear[1] ##1 !irqFlags[1]);

endmodule : cem_event_mask

// File: bench/cem_host_model.sv
// host-side model driving the register access port
`timescale 1ns/1ps
module cem_host_model (
   input wire logic sys_clk,
   output logic [7:0] regAddr,
   output logic regWrEn,
   output logic [7:0] regWrData,
   output logic regRdEn
);
   initial begin
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regWrData = 8'h00;
      regRdEn = 1'b0;
   end
   // one access per call, strobe held across exactly one rising edge
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= wr;
      regRdEn <= !wr;
      @(negedge sys_clk);
      regWrEn <= 1'b0;
      regRdEn <= 1'b0;
      // released bus shows the inverse, so a stale value cannot pass
      regAddr <= ~a;
      regWrData <= ~d;
   endtask : access
endmodule : cem_host_model

// File: bench/converter_event_mask_regs_bench.sv
// self-checking bench of the converter event mask block
`timescale 1ns/1ps
module converter_event_mask_regs_bench;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] convBelowGood = 4'h0;
   logic [3:0] convCurLimit = 4'h0;
   logic [7:0] flagClear = 8'h00;
   logic [7:0] regAddr, regWrData, regRdData, irqFlags, d;
   logic [3:0] convGoodRaw, convOvercurrentRaw;
   logic regWrEn, regRdEn, hostIrqLineN;
   logic rdSeen = 1'b0;
   logic [15:0] m;
   logic [24:0] got;
   logic [24:0] expQ[$];
   int n_mismatch = 0;
   int samples_checked = 0;
   int seed = 32'h1eab9505;
   initial forever #12.5 sys_clk = ~sys_clk;
   cem_event_mask dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .convBelowGood(convBelowGood),
      .convCurLimit(convCurLimit), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
      .regRdEn(regRdEn), .flagClear(flagClear), .regRdData(regRdData), .convGoodRaw(convGoodRaw),
      .convOvercurrentRaw(convOvercurrentRaw), .irqFlags(irqFlags), .hostIrqLineN(hostIrqLineN));
   cem_host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn));
   // note the expected answer, then issue the read
   task automatic chk(input logic [7:0] a, input logic [7:0] v, input logic [7:0] fl, input logic [3:0] r);
      expQ.push_back({fl == 8'h00, fl, r, r, v});
      host.access(1'b0, a, 8'h00);
   endtask : chk
   // read answer is settled by the falling edge after the read edge
   always @(posedge sys_clk) rdSeen <= regRdEn;
   always @(negedge sys_clk) begin
      if (rdSeen) begin
         got = {hostIrqLineN, irqFlags, convGoodRaw, convOvercurrentRaw, regRdData};
         samples_checked++;
         if (expQ.size() == 0 || got !== expQ[0]) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, expQ.size() ? expQ[0] : 25'h0);
         end
         if (expQ.size() != 0) void'(expQ.pop_front());
      end
   end
   task automatic results;
      if (expQ.size() != 0) n_mismatch++;
      $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   initial begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) sys_rst = 1'b0;
      chk(8'h1f, 8'h44, 8'h00, 4'h0);
      chk(8'h20, 8'h44, 8'h00, 4'h0);
      // random masks, with an unmapped write that must not land
      for (int r = 0; r < 2; r++) begin
         d = 8'($random(seed));
         host.access(1'b1, 8'h1f + 8'(r), d);
         host.access(1'b1, 8'h21, ~d);
         chk(8'h1f + 8'(r), d & 8'hdd, 8'h00, 4'h0);
      end
      chk(8'h21, 8'h00, 8'h00, 4'h0);
      // all eight events fire together; only one mask bit is open each pass
      for (int e = 0; e < 8; e++) begin
         m = ~(16'h1 << ((e / 4) * 8 + ((e / 2) % 2) * 4 + (e % 2) * 2));
         host.access(1'b1, 8'h1f, m[7:0]);
         host.access(1'b1, 8'h20, m[15:8]);
         convBelowGood = 4'hf;
         convCurLimit = 4'hf;
         repeat (4) @(negedge sys_clk);
         chk(8'h1f, m[7:0] & 8'hdd, 8'h01 << e, 4'hf);
         convBelowGood = 4'h0;
         convCurLimit = 4'h0;
         repeat (4) @(negedge sys_clk);
         flagClear = 8'hff;
         @(negedge sys_clk) flagClear = 8'h00;
         chk(8'h20, m[15:8] & 8'hdd, 8'h00, 4'h0);
      end
      repeat (2) @(negedge sys_clk);
      results();
   end
endmodule : converter_event_mask_regs_bench
